/* design/fcc_pkg.sv */
// Package with the configuration register map, field layout and reset values.
package fcc_pkg;
   localparam logic [7:0] FCC_CMD_CONFIG = 8'h04;
   localparam int FCC_BIT_WIPE = 7;
   localparam int FCC_BIT_STEP = 6;
   localparam int FCC_BIT_SRC = 5;
   localparam int FCC_F2_LSB = 3;
   localparam int FCC_F1_LSB = 1;
   localparam int FCC_BIT_PD = 0;
   localparam logic [7:0] FCC_CONFIG_RST = 8'h0A;
   localparam logic [9:0] FCC_STEP_COARSE = 10'h032;
   localparam logic [9:0] FCC_STEP_FINE = 10'h019;
endpackage

/* design/fcc_rpm_scale.sv */
// Per-fan conversion of a counted pulse rate into an RPM output register value.
`timescale 1ns/1ps
module fcc_rpm_scale (
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   input wire logic [15:0] i_pulses_per_min,
   input wire logic [1:0] i_pulses_per_turn,
   input wire logic i_step_fine,
   output logic [8:0] o_rpm
);
   import fcc_pkg::*;
   // A field value n means n+1 pulses per turn.
   logic [15:0] turns_per_min;
   logic [15:0] step_units;
   logic [8:0] rpm_next;
   logic [8:0] rpm_reg;
   assign turns_per_min = i_pulses_per_min / ({14'h0000, i_pulses_per_turn} + 16'h0001); // RULE5
   assign step_units = turns_per_min / (i_step_fine ? {6'h00, FCC_STEP_FINE} : {6'h00, FCC_STEP_COARSE}); // RULE8
   assign rpm_next = (step_units > 16'h01FF) ? 9'h1FF : step_units[8:0];
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) rpm_reg <= 9'h000;
      else rpm_reg <= rpm_next;
   end
   assign o_rpm = rpm_reg;
endmodule // fcc_rpm_scale

/* design/fcc_config_reg.sv */
// Configuration register of a dual-fan speed controller with its control outputs.
//
// How it works
// RULE1: One 8-bit read/write register; every bit reads back what was last written.
// RULE2: Bit 7 fault wipe, 6 step, 5 source, 4:3 fan2, 2:1 fan1, 0 power-down.
// RULE3: Writing 1 to bit 7 clears fan fault flags and releases the alert.
// RULE4: Bit 7 at 0 leaves fault flags alone; it resets to 0.
// RULE5: Each fan's pulses-per-turn field scales its pulse count into RPM.
// RULE6: Power-down bit set enters shutdown; clear keeps normal operation. Here it only drives o_power_down_select; RPM scaling keeps running.
// RULE7: Reset loads bits 3 and 1 high, all others low.
// RULE8: Step select clear gives 50 RPM steps, set gives 25 RPM steps.
// RULE9: The host addresses this register with command code 0x04.
// RULE10: One clear pulse per write of 1; later faults set the flags again.
`timescale 1ns/1ps
module fcc_config_reg (
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire logic [7:0] i_cmd,
   input wire logic [7:0] i_wr_data,
   input wire logic i_fan1_fault_det,
   input wire logic i_fan2_fault_det,
   input wire logic [15:0] i_fan1_pulses_per_min,
   input wire logic [15:0] i_fan2_pulses_per_min,
   output logic [7:0] o_rd_data,
   output logic o_rd_hit,
   output logic o_fault_wipe,
   output logic o_rpm_step_select,
   output logic o_speed_source_select,
   output logic [1:0] o_fan2_pulses_per_turn,
   output logic [1:0] o_fan1_pulses_per_turn,
   output logic o_power_down_select,
   output logic [1:0] o_fan_fault,
   output logic o_alert_n,
   output logic [8:0] o_rpm1,
   output logic [8:0] o_rpm2
);
   import fcc_pkg::*;
   logic [7:0] config_reg;
   logic [7:0] config_next;
   logic [7:0] rd_data_reg;
   logic [7:0] rd_data_next;
   logic rd_hit_reg;
   logic wipe_reg;
   logic [1:0] fault_reg;
   logic [1:0] fault_next;
   logic alert_n_reg;
   logic sel_config;
   logic wr_config;
   logic wipe_req;
   logic [1:0] fault_det;

   assign sel_config = (i_cmd == FCC_CMD_CONFIG); // RULE9
   assign wr_config = i_wr_en && sel_config;
   assign config_next = wr_config ? i_wr_data : config_reg; // RULE1
   assign wipe_req = wr_config && i_wr_data[FCC_BIT_WIPE]; // RULE3 RULE10
   assign rd_data_next = (i_rd_en && sel_config) ? config_reg : 8'h00; // RULE1
   assign fault_det = {i_fan2_fault_det, i_fan1_fault_det};
   // Detection sets win over a wipe landing in the same cycle.
   assign fault_next = fault_det | (wipe_reg ? 2'h0 : fault_reg); // RULE3 RULE4 RULE10

   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         config_reg <= FCC_CONFIG_RST; // RULE7 RULE4
         rd_data_reg <= 8'h00;
         rd_hit_reg <= 1'b0;
         wipe_reg <= 1'b0;
         fault_reg <= 2'h0;
         alert_n_reg <= 1'b1;
      end else begin
         config_reg <= config_next;
         rd_data_reg <= rd_data_next;
         rd_hit_reg <= i_rd_en && sel_config;
         wipe_reg <= wipe_req; // RULE10
         fault_reg <= fault_next;
         alert_n_reg <= ~|fault_next; // RULE3
      end
   end

   assign o_rd_data = rd_data_reg;
   assign o_rd_hit = rd_hit_reg;
   assign o_fault_wipe = wipe_reg;
   assign o_rpm_step_select = config_reg[FCC_BIT_STEP]; // RULE2 RULE8
   assign o_speed_source_select = config_reg[FCC_BIT_SRC]; // RULE2
   assign o_fan2_pulses_per_turn = config_reg[FCC_F2_LSB +: 2]; // RULE2
   assign o_fan1_pulses_per_turn = config_reg[FCC_F1_LSB +: 2]; // RULE2
   assign o_power_down_select = config_reg[FCC_BIT_PD]; // RULE6
   assign o_fan_fault = fault_reg;
   assign o_alert_n = alert_n_reg;

   fcc_rpm_scale u_rpm1 (
      .i_clk_sys(i_clk_sys),
      .i_nrst(i_nrst),
      .i_pulses_per_min(i_fan1_pulses_per_min),
      .i_pulses_per_turn(config_reg[FCC_F1_LSB +: 2]),
      .i_step_fine(config_reg[FCC_BIT_STEP]),
      .o_rpm(o_rpm1)
   ); // RULE5

   fcc_rpm_scale u_rpm2 (
      .i_clk_sys(i_clk_sys),
      .i_nrst(i_nrst),
      .i_pulses_per_min(i_fan2_pulses_per_min),
      .i_pulses_per_turn(config_reg[FCC_F2_LSB +: 2]),
      .i_step_fine(config_reg[FCC_BIT_STEP]),
      .o_rpm(o_rpm2)
   ); // RULE5
endmodule // fcc_config_reg

/* verification/fcc_host.sv */
// Host model that issues single-byte register writes and reads.
`timescale 1ns/1ps
module fcc_host (input wire logic i_clk_sys, input wire logic [7:0] o_rd_data,
   output logic i_wr_en = 0, i_rd_en = 0, output logic [7:0] i_cmd = 8'h00, i_wr_data = 8'h00);
   task automatic xfer(input logic w, input logic [7:0] c, d, output logic [7:0] q);
      @(posedge i_clk_sys);
      {i_wr_en, i_rd_en, i_cmd, i_wr_data} <= {w, !w, c, d};
      @(posedge i_clk_sys);
      {i_wr_en, i_rd_en, i_wr_data} <= {2'b00, ~d};
      #1 q = o_rd_data;
   endtask
endmodule // fcc_host

/* verification/fcc_config_reg_properties.sv */
// Checker of the configuration register port behaviour.
`timescale 1ns/1ps
module fcc_config_reg_properties import fcc_pkg::*; (
   input wire logic i_clk_sys, i_nrst, i_wr_en, i_rd_en, i_fan1_fault_det, i_fan2_fault_det, o_rd_hit,
   input wire logic o_fault_wipe, o_rpm_step_select, o_speed_source_select, o_power_down_select, o_alert_n,
   input wire logic [7:0] i_cmd, i_wr_data, o_rd_data,
   input wire logic [1:0] o_fan2_pulses_per_turn, o_fan1_pulses_per_turn, o_fan_fault);
   wire logic [6:0] f = {o_rpm_step_select, o_speed_source_select, o_fan2_pulses_per_turn,
      o_fan1_pulses_per_turn, o_power_down_select};
   wire logic wr = i_wr_en && i_cmd == FCC_CMD_CONFIG;
   wire logic rd = i_rd_en && i_cmd == FCC_CMD_CONFIG;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_nrst);
   sequence s_wipe_clear;
      o_fault_wipe ##1 (o_fan_fault & ~$past({i_fan2_fault_det, i_fan1_fault_det})) == 2'b00;
   endsequence
   write_fields_a: assert property (wr |=> f == $past(i_wr_data[6:0])) else $error("bad fields");
   hold_fields_a: assert property (!wr |=> $stable(f)) else $error("fields moved");
   read_back_a: assert property (rd |=> o_rd_hit && o_rd_data[6:0] == $past(f)) else $error("bad read");
   refuse_read_a: assert property (!rd |=> !o_rd_hit && o_rd_data == 8'h00) else $error("bad idle");
   wipe_clear_a: assert property (wr && i_wr_data[7] |=> s_wipe_clear) else $error("no clear");
   no_wipe_a: assert property (!(wr && i_wr_data[7]) |=> !o_fault_wipe) else $error("stray wipe");
   alert_level_a: assert property (o_alert_n == (o_fan_fault == 2'b00)) else $error("bad alert");
   reset_value_a: assert property ($rose(i_nrst) |-> f == FCC_CONFIG_RST[6:0]) else $error("bad reset");
endmodule // fcc_config_reg_properties
bind fcc_config_reg fcc_config_reg_properties chk (.*);

/* verification/fcc_config_reg_tb.sv */
// Self-checking bench of the configuration register.
`timescale 1ns/1ps
module fcc_config_reg_tb;
   import fcc_pkg::*;
   logic i_clk_sys = 0, i_nrst = 0, det = 0;
   logic i_wr_en, i_rd_en, o_rd_hit, o_fault_wipe, o_alert_n, o_rpm_step_select, o_speed_source_select;
   logic o_power_down_select;
   logic [7:0] i_cmd, i_wr_data, o_rd_data, q;
   logic [1:0] o_fan2_pulses_per_turn, o_fan1_pulses_per_turn, o_fan_fault;
   logic [8:0] o_rpm1, o_rpm2;
   logic [15:0] ppm = 16'h03E8;
   logic [23:0] rows [5] = '{24'h045555, 24'h04AAAA, 24'h0300AA, 24'h040000, 24'h044E4E};
   int n_mismatch = 0, comparisons = 0;
   initial forever #12.5 i_clk_sys = ~i_clk_sys;
   fcc_host host (.*);
   fcc_config_reg DUT (.*, .i_fan1_fault_det(det), .i_fan2_fault_det(det), .i_fan1_pulses_per_min(ppm),
      .i_fan2_pulses_per_min(ppm));
   task automatic chk(input logic [15:0] g, e);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic results;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #100000 n_mismatch++;
      results();
   end
   initial begin
      repeat (12) @(posedge i_clk_sys);
      i_nrst <= 1;
      host.xfer(0, FCC_CMD_CONFIG, 8'h00, q);
      chk(q, FCC_CONFIG_RST);
      chk(o_alert_n, 1'b1);
      foreach (rows[i]) begin
         host.xfer(1, rows[i][23:16], rows[i][15:8], q);
         host.xfer(0, FCC_CMD_CONFIG, 8'h00, q);
         chk(q, rows[i][7:0]);
      end
      chk(o_rpm1, 16'h000A);
      chk(o_rpm2, 16'h0014);
      @(posedge i_clk_sys) det <= 1;
      @(posedge i_clk_sys) det <= 0;
      @(posedge i_clk_sys) #1 chk({o_alert_n, o_fan_fault}, 16'h0003);
      host.xfer(1, FCC_CMD_CONFIG, 8'h80, q);
      @(posedge i_clk_sys) #1 chk({o_alert_n, o_fan_fault}, 16'h0004);
      @(posedge i_clk_sys) det <= 1;
      @(posedge i_clk_sys) det <= 0;
      @(posedge i_clk_sys) #1 chk({o_alert_n, o_fan_fault}, 16'h0003);
      @(posedge i_clk_sys) i_nrst <= 0;
      repeat (2) @(posedge i_clk_sys);
      i_nrst <= 1;
      host.xfer(0, FCC_CMD_CONFIG, 8'h00, q);
      chk(q, FCC_CONFIG_RST);
      chk({o_alert_n, o_fan_fault}, 16'h0004);
      chk(o_rpm1, 16'h000A);
      host.xfer(0, 8'h05, 8'h00, q);
      chk(q, 16'h0000);
      results();
   end
endmodule // fcc_config_reg_tb
